// File: core/dhs_pkg.sv
// Purpose: constants and types for the drive homing sequencer
// Assumes: 25 MHz clock, synchronous active-low reset
// Notes:   parameter words arrive over a plain write port (index + data + strobe)
// How it works
// - homing start enters internal position control, accelerates
// - referenced status cleared on homing start
// - cyclic commands ignored while homing active
// - marker pulse triggers deceleration to standstill
// - complete only after stop and command load
// - referenced status set on successful completion
// - command reset returns to cyclic command following
// - interrupted homing leaves status unreferenced
// - class-one error aborts homing with error
// - reference point from offset and distance
// - decode direction, switch, feedback option bits
// - fixed option bits checked, reserved ignored
// - one reference offset for both feedbacks
// - homing runs only in position control mode
// - last written of options/method governs
// - negative method codes run to endstop
// - positive method codes: switches, impulse, none
`default_nettype none
package dhs_pkg;
  // ==========================================
  // parameter indices on the write port
  localparam logic [2:0] IDX_CMD     = 3'h0;
  localparam logic [2:0] IDX_OPTIONS = 3'h1;
  localparam logic [2:0] IDX_METHOD  = 3'h2;
  localparam logic [2:0] IDX_VEL     = 3'h3;
  localparam logic [2:0] IDX_ACC     = 3'h4;
  localparam logic [2:0] IDX_REF_DST = 3'h5;
  localparam logic [2:0] IDX_REF_OFS = 3'h6;
  // ==========================================
  // option and command bit positions
  localparam int OPT_DIR   = 0;
  localparam int OPT_SW    = 2;
  localparam int OPT_EXTFB = 3;
  localparam int OPT_SWEVL = 5;
  localparam int OPT_MARK  = 6;
  localparam int OPT_FINAL = 7;
  localparam int OPT_DIST  = 8;
  localparam int CMD_SET   = 0;
  localparam int CMD_EN    = 1;
  // ==========================================
  // method codes
  localparam logic signed [15:0] M_ES_POS    = -16'sd18;
  localparam logic signed [15:0] M_ES_NEG    = -16'sd17;
  localparam logic signed [15:0] M_ESZ_POS   = -16'sd2;
  localparam logic signed [15:0] M_ESZ_NEG   = -16'sd1;
  localparam logic signed [15:0] M_LSZ_NEG   = 16'sd1;
  localparam logic signed [15:0] M_LSZ_POS   = 16'sd2;
  localparam logic signed [15:0] M_RSZ_POS   = 16'sd7;
  localparam logic signed [15:0] M_RSZ_NEG   = 16'sd11;
  localparam logic signed [15:0] M_LS_NEG    = 16'sd17;
  localparam logic signed [15:0] M_LS_POS    = 16'sd18;
  localparam logic signed [15:0] M_RS_POS    = 16'sd23;
  localparam logic signed [15:0] M_RS_NEG    = 16'sd27;
  localparam logic signed [15:0] M_Z_NEG     = 16'sd33;
  localparam logic signed [15:0] M_Z_POS     = 16'sd34;
  localparam logic signed [15:0] M_NONE      = 16'sd35;
  // ==========================================
  // reset values
  localparam logic [15:0] OPTIONS_RST = 16'h0144;
  localparam logic [15:0] METHOD_RST  = 16'h0022;
  localparam logic [31:0] ZERO32      = 32'h0000_0000;
  // ==========================================
  // types
  typedef enum logic [1:0] {DHS_IDLE, DHS_RUN, DHS_DONE, DHS_FAIL} dhs_cmd_state_e;
  typedef enum logic [1:0] {DHS_TGT_ENDSTOP, DHS_TGT_LIMIT, DHS_TGT_REFSW,
                            DHS_TGT_IMPULSE} dhs_target_e;
  typedef enum {DHS_S_IDLE, DHS_S_ACCEL, DHS_S_SEEK, DHS_S_DECEL, DHS_S_LOAD,
                DHS_S_DONE, DHS_S_FAIL} dhs_seq_e;
endpackage : dhs_pkg
`default_nettype wire

// File: core/dhs_method_decode.sv
// Purpose: decode options word or method code into a homing plan
// Assumes: selector says which of the two was written last
// Notes:   unknown method codes flag invalid rather than guess
`default_nettype none
module dhs_method_decode
  import dhs_pkg::*;
(
  // inputs
  input  wire logic        [15:0] options,
  input  wire logic signed [15:0] method,
  input  wire logic               use_method,
  // plan
  output logic                    dir_neg,
  output logic                    ext_fb,
  output dhs_target_e             target,
  output logic                    ref_on_impulse,
  output logic                    no_motion,
  output logic                    valid
);
  // ==========================================
  // options word path
  wire opt_ok = ~options[OPT_SWEVL] & options[OPT_MARK]
              & ~options[OPT_FINAL] & options[OPT_DIST];
  wire opt_dir = options[OPT_DIR];
  wire opt_sw  = options[OPT_SW];
  // ==========================================
  // method code path
  logic        m_dir;
  dhs_target_e m_tgt;
  logic        m_imp;
  logic        m_none;
  logic        m_ok;
  always_comb
  begin
    m_dir  = 1'b0;
    m_tgt  = DHS_TGT_IMPULSE;
    m_imp  = 1'b1;
    m_none = 1'b0;
    m_ok   = 1'b1;
    case (method)
      M_ES_POS:  begin m_tgt = DHS_TGT_ENDSTOP; m_imp = 1'b0; end
      M_ES_NEG:  begin m_tgt = DHS_TGT_ENDSTOP; m_imp = 1'b0; m_dir = 1'b1; end
      M_ESZ_POS: m_tgt = DHS_TGT_ENDSTOP;
      M_ESZ_NEG: begin m_tgt = DHS_TGT_ENDSTOP; m_dir = 1'b1; end
      M_LSZ_NEG: begin m_tgt = DHS_TGT_LIMIT; m_dir = 1'b1; end
      M_LSZ_POS: m_tgt = DHS_TGT_LIMIT;
      M_RSZ_POS: m_tgt = DHS_TGT_REFSW;
      M_RSZ_NEG: begin m_tgt = DHS_TGT_REFSW; m_dir = 1'b1; end
      M_LS_NEG:  begin m_tgt = DHS_TGT_LIMIT; m_imp = 1'b0; m_dir = 1'b1; end
      M_LS_POS:  begin m_tgt = DHS_TGT_LIMIT; m_imp = 1'b0; end
      M_RS_POS:  begin m_tgt = DHS_TGT_REFSW; m_imp = 1'b0; end
      M_RS_NEG:  begin m_tgt = DHS_TGT_REFSW; m_imp = 1'b0; m_dir = 1'b1; end
      M_Z_NEG:   m_dir = 1'b1;
      M_Z_POS:   m_dir = 1'b0;
      M_NONE:    begin m_none = 1'b1; m_imp = 1'b0; end
      default:   m_ok = 1'b0;
    endcase
  end
  // ==========================================
  // select by last write; feedback bit always from options
  assign dir_neg        = use_method ? m_dir  : opt_dir;
  assign target         = use_method ? m_tgt  : (opt_sw ? DHS_TGT_REFSW : DHS_TGT_IMPULSE);
  assign ref_on_impulse = use_method ? m_imp  : 1'b1;
  assign no_motion      = use_method ? m_none : 1'b0;
  assign valid          = use_method ? m_ok   : opt_ok;
  assign ext_fb         = options[OPT_EXTFB];
endmodule : dhs_method_decode
`default_nettype wire

// File: core/dhs_sequencer.sv
// Purpose: drive-side homing procedure sequencer
// Assumes: motion profile reports speed reached and standstill
// Notes:   sensor pins synchronised here; events are single-cycle after sync
`default_nettype none
module dhs_sequencer
  import dhs_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // parameter write port
  input  wire logic               par_we,
  input  wire logic [2:0]         par_idx,
  input  wire logic [31:0]        par_wdata,
  // parameter read back
  output logic [15:0]             homing_command,
  output logic [15:0]             homing_options,
  output logic signed [15:0]      homing_method_code,
  // cyclic command from master
  input  wire logic signed [31:0] cyc_pos_cmd,
  input  wire logic               pos_mode,
  // drive sensors and status
  input  wire logic               marker_pin,
  input  wire logic               home_sw_pin,
  input  wire logic               limit_pin,
  input  wire logic               endstop_pin,
  input  wire logic               class_one_diagnostic_error,
  input  wire logic               at_velocity,
  input  wire logic               standstill,
  input  wire logic signed [31:0] actual_pos,
  // motion profile request
  output logic                    int_pos_ctrl,
  output logic                    move_en,
  output logic                    move_neg,
  output logic                    decel,
  output logic [31:0]             prof_vel,
  output logic [31:0]             prof_acc,
  output logic                    ext_fb_sel,
  // results
  output logic signed [31:0]      pos_cmd,
  output logic                    pos_referenced,
  output dhs_cmd_state_e          cmd_state
);
  // ==========================================
  // parameter store
  logic [31:0]        home_vel;
  logic [31:0]        home_acc;
  logic signed [31:0] ref_dist;
  logic signed [31:0] ref_ofs;
  logic               use_method;
  wire we_cmd = par_we & (par_idx == IDX_CMD);
  wire we_opt = par_we & (par_idx == IDX_OPTIONS);
  wire we_met = par_we & (par_idx == IDX_METHOD);
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      homing_command     <= 16'h0000;
      homing_options     <= OPTIONS_RST;
      homing_method_code <= METHOD_RST;
      home_vel           <= ZERO32;
      home_acc           <= ZERO32;
      ref_dist           <= ZERO32;
      ref_ofs            <= ZERO32;
      use_method         <= 1'b0;
    end
    else
    begin
      if (we_cmd) homing_command <= par_wdata[15:0];
      if (we_opt) homing_options <= par_wdata[15:0];
      if (we_met) homing_method_code <= par_wdata[15:0];
      if (we_met) use_method <= 1'b1;
      else if (we_opt) use_method <= 1'b0;
      if (par_we && par_idx == IDX_VEL) home_vel <= par_wdata;
      if (par_we && par_idx == IDX_ACC) home_acc <= par_wdata;
      if (par_we && par_idx == IDX_REF_DST) ref_dist <= par_wdata;
      if (par_we && par_idx == IDX_REF_OFS) ref_ofs <= par_wdata;
    end
  end
  // ==========================================
  // plan decode
  logic        dir_neg;
  logic        ext_fb;
  dhs_target_e target;
  logic        ref_imp;
  logic        no_motion;
  logic        plan_ok;
  dhs_method_decode u_decode (
    .options        (homing_options),
    .method         (homing_method_code),
    .use_method     (use_method),
    .dir_neg        (dir_neg),
    .ext_fb         (ext_fb),
    .target         (target),
    .ref_on_impulse (ref_imp),
    .no_motion      (no_motion),
    .valid          (plan_ok)
  );
  // ==========================================
  // pin synchronisers, three flops each, the third for edge detect
  localparam int NPIN = 4;
  wire  [NPIN-1:0] pin_raw = {endstop_pin, limit_pin, home_sw_pin, marker_pin};
  wire  [NPIN-1:0] pin_s2;
  wire  [NPIN-1:0] pin_s3;
  genvar g;
  generate
    for (g = 0; g < NPIN; g++)
    begin : g_sync
      // flops are local so each bit has one process; s1 feeds only s2
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
        end
        else
        begin
          s1 <= pin_raw[g];
          s2 <= s1;
          s3 <= s2;
        end
      end
      assign pin_s2[g] = s2;
      assign pin_s3[g] = s3;
    end
  endgenerate
  wire  [NPIN-1:0] pin_rise = pin_s2 & ~pin_s3;
  // either edge of the home switch counts as reaching it
  wire  sw_fall = pin_s3[1] & ~pin_s2[1];
  // ==========================================
  // command handshake
  wire cmd_on  = homing_command[CMD_SET] & homing_command[CMD_EN];
  // target reached, then optional zero impulse as marker
  wire tgt_hit = (target == DHS_TGT_ENDSTOP) ? pin_rise[3] :
                 (target == DHS_TGT_LIMIT)   ? pin_rise[2] :
                 (target == DHS_TGT_REFSW)   ? (pin_rise[1] | sw_fall) :
                 pin_rise[0];
  logic tgt_seen;
  wire  marker_ev = (target == DHS_TGT_IMPULSE) ? pin_rise[0] :
                    ref_imp ? (tgt_seen & pin_rise[0]) : tgt_hit;
  // ==========================================
  // sequencer
  dhs_seq_e st;
  dhs_seq_e next_st;
  logic signed [31:0] mark_pos;
  wire abort = ~cmd_on | class_one_diagnostic_error | ~pos_mode;
  always_comb
  begin
    next_st = st;
    case (st)
      DHS_S_IDLE:
        if (cmd_on && pos_mode && plan_ok)
          next_st = no_motion ? DHS_S_LOAD : DHS_S_ACCEL;
        else if (cmd_on)
          next_st = DHS_S_FAIL;
      DHS_S_ACCEL:
        if (abort) next_st = class_one_diagnostic_error ? DHS_S_FAIL : DHS_S_IDLE;
        else if (marker_ev) next_st = DHS_S_DECEL;
        else if (at_velocity) next_st = DHS_S_SEEK;
      DHS_S_SEEK:
        if (abort) next_st = class_one_diagnostic_error ? DHS_S_FAIL : DHS_S_IDLE;
        else if (marker_ev) next_st = DHS_S_DECEL;
      DHS_S_DECEL:
        if (abort) next_st = class_one_diagnostic_error ? DHS_S_FAIL : DHS_S_IDLE;
        else if (standstill) next_st = DHS_S_LOAD;
      DHS_S_LOAD:
        if (abort) next_st = class_one_diagnostic_error ? DHS_S_FAIL : DHS_S_IDLE;
        else next_st = DHS_S_DONE;
      DHS_S_DONE:
        if (!cmd_on) next_st = DHS_S_IDLE;
      DHS_S_FAIL:
        if (!cmd_on) next_st = DHS_S_IDLE;
      default: next_st = DHS_S_IDLE;
    endcase
  end
  wire moving   = (st == DHS_S_ACCEL) | (st == DHS_S_SEEK) | (st == DHS_S_DECEL);
  wire starting = (st == DHS_S_IDLE) & (next_st == DHS_S_ACCEL | next_st == DHS_S_LOAD);
  // reference point: marker position plus offset maps to reference distance
  wire signed [31:0] ref_point_pos = mark_pos + ref_ofs;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st             <= DHS_S_IDLE;
      tgt_seen       <= 1'b0;
      mark_pos       <= ZERO32;
      pos_cmd        <= ZERO32;
      pos_referenced <= 1'b0;
    end
    else
    begin
      st <= next_st;
      if (starting) tgt_seen <= 1'b0;
      else if (moving && tgt_hit) tgt_seen <= 1'b1;
      if (starting && no_motion) mark_pos <= actual_pos - ref_ofs;
      else if (moving && marker_ev && st != DHS_S_DECEL) mark_pos <= actual_pos;
      if (starting) pos_referenced <= 1'b0;
      else if (next_st == DHS_S_DONE && st == DHS_S_LOAD)
        pos_referenced <= 1'b1;
      if (st == DHS_S_LOAD)
        pos_cmd <= ref_dist + (actual_pos - ref_point_pos);
      else if (st == DHS_S_IDLE && !starting)
        pos_cmd <= cyc_pos_cmd;
    end
  end
  // ==========================================
  // outputs to motion profile
  assign int_pos_ctrl = moving | (st == DHS_S_LOAD) | (st == DHS_S_DONE);
  assign move_en      = (st == DHS_S_ACCEL) | (st == DHS_S_SEEK);
  assign decel        = (st == DHS_S_DECEL);
  assign move_neg     = dir_neg;
  assign prof_vel     = home_vel;
  assign prof_acc     = home_acc;
  assign ext_fb_sel   = ext_fb;
  assign cmd_state    = (st == DHS_S_DONE) ? DHS_DONE :
                        (st == DHS_S_FAIL) ? DHS_FAIL :
                        (st == DHS_S_IDLE) ? DHS_IDLE : DHS_RUN;
endmodule : dhs_sequencer
`default_nettype wire

// File: verif/dhs_asserts.sv
// Purpose: port assertions for the homing sequencer
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to the sequencer from the bench top
`default_nettype none
module dhs_asserts
  import dhs_pkg::*;
(
  // clock and reset
  input wire logic               clk,
  input wire logic               rst_n,
  // watched ports
  input wire logic        [15:0] homing_command,
  input wire logic signed [15:0] homing_method_code,
  input wire logic signed [31:0] cyc_pos_cmd,
  input wire logic               pos_mode,
  input wire logic               marker_pin,
  input wire logic               class_one_diagnostic_error,
  input wire logic               standstill,
  input wire logic               int_pos_ctrl,
  input wire logic               move_en,
  input wire logic               decel,
  input wire logic signed [31:0] pos_cmd,
  input wire logic               pos_referenced,
  input wire dhs_cmd_state_e     cmd_state
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // helpers
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire run  = cmd_state == DHS_RUN;
  wire idle = cmd_state == DHS_IDLE;
  // ==========================================
  // properties
  property p_run_internal; run |-> int_pos_ctrl; endproperty
  a_run_internal: assert property (p_run_internal) else $error("homing without internal control");
  property p_run_unref; run |-> !pos_referenced; endproperty
  a_run_unref: assert property (p_run_unref) else $error("referenced while homing");
  property p_hold_cmd; $past(run) && run |-> $stable(pos_cmd); endproperty
  a_hold_cmd: assert property (p_hold_cmd) else $error("command moved while homing");
  // sync plus edge detect costs three cycles, two spare
  property p_marker_decel;
    run && move_en && !decel && homing_method_code == M_Z_POS && $rose(marker_pin)
      |-> ##[1:5] decel;
  endproperty
  a_marker_decel: assert property (p_marker_decel) else $error("no braking after marker");
  property p_done_ref; $rose(pos_referenced) |-> cmd_state == DHS_DONE && standstill; endproperty
  a_done_ref: assert property (p_done_ref) else $error("referenced too early");
  property p_follow;
    idle && $past(idle) && $past(rst_n) && $stable(cyc_pos_cmd) |-> pos_cmd == cyc_pos_cmd;
  endproperty
  a_follow: assert property (p_follow) else $error("idle command not followed");
  property p_abort_unref; $past(run) && idle |-> !pos_referenced; endproperty
  a_abort_unref: assert property (p_abort_unref) else $error("aborted run referenced");
  property p_c1d_abort; run && class_one_diagnostic_error |-> ##[1:3] cmd_state == DHS_FAIL; endproperty
  a_c1d_abort: assert property (p_c1d_abort) else $error("error did not abort");
  property p_mode_gate;
    $past(idle) && !$past(pos_mode) && !idle |-> cmd_state == DHS_FAIL;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("ran outside position mode");
  property p_done_hold; cmd_state == DHS_DONE && homing_command[1:0] == 2'h3 |=> cmd_state == DHS_DONE; endproperty
  a_done_hold: assert property (p_done_hold) else $error("completion not held");
  c_done: cover property ($rose(cmd_state == DHS_DONE));
  c_fail: cover property ($rose(cmd_state == DHS_FAIL));
  c_decel: cover property ($rose(decel));
endmodule : dhs_asserts
`default_nettype wire

// File: verif/dhs_motion_model.sv
// Purpose: axis and profile stand-in for the homing sequencer
// Assumes: one position step per cycle while moving
// Notes:   axis freezes at the marker, so the latch moment is moot
`default_nettype none
module dhs_motion_model
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // profile request
  input  wire logic          move_en,
  input  wire logic          decel,
  input  wire logic          move_neg,
  // travel to marker, stop time: slow or prompt
  input  wire logic [7:0]    seek_len,
  input  wire logic [7:0]    stop_len,
  // status back
  output logic               at_velocity,
  output logic               standstill,
  output logic signed [31:0] actual_pos,
  output logic               marker_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int  ramp;
  int  trav;
  int  stp;
  wire moving = move_en && !decel && !marker_pin;
  always @(posedge clk)
  begin
    ramp <= move_en ? ramp + 1 : 0;
    stp <= decel ? stp + 1 : 0;
    trav <= !move_en ? 0 : trav + (at_velocity ? 1 : 0);
    actual_pos <= !rst_n ? 32'sh0000_1000 : actual_pos + (moving ? (move_neg ? -1 : 1) : 0);
  end
  assign at_velocity = ramp >= 4;
  assign marker_pin = move_en && trav >= seek_len;
  // braking takes stop_len cycles; only an idle axis is still at once
  assign standstill = (!move_en && !decel) || (decel && stp >= stop_len);
endmodule : dhs_motion_model
`default_nettype wire

// File: verif/test_drive_homing_sequencer.sv
// Purpose: self-checking bench for the homing sequencer
// Assumes: 25 MHz clock, reset held 20 cycles
// Notes:   expectations come from the rules, never from outputs
`default_nettype none
module test_drive_homing_sequencer
  import dhs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // signals
  logic               clk = 1'b0, rst_n = 1'b0, par_we = 1'b0, pos_mode = 1'b1, c1d = 1'b0;
  logic [2:0]         idx = 3'h0;
  logic [31:0]        wdata = 32'h0;
  logic signed [31:0] cyc = 32'sh0;
  logic [7:0]         seek_len = 8'hC8, stop_len = 8'h01;
  logic [2:0]         sw = 3'h0;
  logic               at_vel, stand, mk, mv, dc, mn, ipc, efb, refd;
  logic signed [31:0] apos, pcmd;
  logic [31:0]        pvel, pacc;
  logic [15:0]        hc, ho;
  logic signed [15:0] hm;
  dhs_cmd_state_e     st;
  int                 miscompares = 0, total_checks = 0, exp_pos, k, rv;
  int                 codes[15] = '{-18, -17, -2, -1, 1, 2, 7, 11, 17, 18, 23, 27, 33, 34, 35};
  bit                 negs[15] = '{0, 1, 0, 1, 1, 0, 0, 1, 1, 0, 0, 1, 1, 0, 0};
  logic [15:0]        opts[$] = '{16'h0145, 16'h014C, 16'h0104};
  always #20 clk = ~clk;
  dhs_sequencer dut (.clk, .rst_n, .par_we, .par_idx(idx), .par_wdata(wdata),
    .homing_command(hc), .homing_options(ho), .homing_method_code(hm), .cyc_pos_cmd(cyc),
    .pos_mode, .marker_pin(mk), .home_sw_pin(sw[0]), .limit_pin(sw[1]), .endstop_pin(sw[2]),
    .class_one_diagnostic_error(c1d), .at_velocity(at_vel), .standstill(stand),
    .actual_pos(apos), .int_pos_ctrl(ipc), .move_en(mv), .move_neg(mn), .decel(dc),
    .prof_vel(pvel), .prof_acc(pacc), .ext_fb_sel(efb), .pos_cmd(pcmd),
    .pos_referenced(refd), .cmd_state(st));
  dhs_motion_model u_axis (.clk, .rst_n, .move_en(mv), .decel(dc), .move_neg(mn), .seek_len,
    .stop_len, .at_velocity(at_vel), .standstill(stand), .actual_pos(apos), .marker_pin(mk));
  // ==========================================
  // tasks
  task automatic end_sim();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] i, input logic [31:0] d);
    @(negedge clk);
    par_we = 1'b1;
    idx = i;
    wdata = d;
    @(negedge clk);
    par_we = 1'b0;
  endtask : wr
  // shake scrambles the cyclic command every cycle of the wait
  task automatic wait_st(input dhs_cmd_state_e s, input bit shake);
    int n;
    n = 0;
    while (st !== s && n < 3000)
    begin
      @(negedge clk);
      n++;
      if (shake)
        cyc = $urandom;
    end
    chk(st, s, "state");
    if (n >= 3000)
      end_sim();
  endtask : wait_st
  // ==========================================
  // main sequence
  initial
  begin
    rv = $urandom(32'h57AF);
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    chk({ho, hm, hc, 14'h0, st}, {OPTIONS_RST, METHOD_RST, 30'h0, DHS_IDLE}, "reset");
    chk({refd, ipc, mv, dc, pcmd}, 36'h0, "reset outputs");
    $display("reset test done");
    for (k = 0; k < 15; k++)
    begin
      wr(IDX_METHOD, codes[k]);
      wr(IDX_CMD, 32'h3);
      repeat (3) @(negedge clk);
      chk({hm, st == DHS_FAIL || (k < 14 && mn !== negs[k])}, {codes[k][15:0], 1'b0}, "code");
      wr(IDX_CMD, 32'h0);
      wait_st(DHS_IDLE, 0);
    end
    $display("method code test done");
    // last slot writes an unlisted method code instead of options
    for (k = 0; k < 4; k++)
    begin
      if (k < 3)
        wr(IDX_OPTIONS, opts[k]);
      else
        wr(IDX_METHOD, 32'h5);
      wr(IDX_CMD, 32'h3);
      repeat (3) @(negedge clk);
      if (k == 3 || (opts[k] & 16'h01E0) != 16'h0140)
        chk(st, DHS_FAIL, "invalid plan");
      else
        chk({st, mn, efb}, {DHS_RUN, opts[k][0], opts[k][3]}, "option plan");
      wr(IDX_CMD, 32'h0);
      wait_st(DHS_IDLE, 0);
    end
    $display("options test done");
    for (k = 0; k < 2; k++)
    begin
      rv = $urandom;
      wr(IDX_REF_DST, rv);
      exp_pos = rv;
      rv = $urandom;
      wr(IDX_REF_OFS, rv);
      exp_pos = exp_pos - rv;
      wr(IDX_VEL, rv ^ 32'h55);
      wr(IDX_ACC, rv);
      chk({pvel, pacc}, {rv ^ 32'h55, rv}, "profile");
      wr(IDX_METHOD, 32'd34);
      seek_len = 8'(8 + $urandom % 32);
      stop_len = k ? 8'h28 : 8'h01;
      wr(IDX_CMD, 32'h3);
      wait_st(DHS_RUN, 1);
      chk({refd, ipc}, 2'b01, "start");
      wait_st(DHS_DONE, 1);
      chk({refd, pcmd}, {1'b1, exp_pos}, "reference point");
      cyc = exp_pos;
      wr(IDX_CMD, 32'h0);
      wait_st(DHS_IDLE, 0);
      cyc = exp_pos + 7;
      repeat (2) @(negedge clk);
      chk(pcmd, cyc, "follow");
    end
    $display("homing run test done");
    // reference switch, limit switch, endstop: each pin ends the seek
    for (k = 0; k < 3; k++)
    begin
      wr(IDX_METHOD, k == 0 ? 32'd23 : k == 1 ? 32'd17 : -32'sd18);
      wr(IDX_CMD, 32'h3);
      wait_st(DHS_RUN, 1);
      repeat (6) @(negedge clk);
      sw[k] = 1'b1;
      wait_st(DHS_DONE, 1);
      chk({refd, mn}, {1'b1, k == 1}, "switch homing");
      sw = 3'h0;
      wr(IDX_CMD, 32'h0);
      wait_st(DHS_IDLE, 0);
    end
    $display("switch test done");
    for (k = 0; k < 3; k++)
    begin
      pos_mode = (k != 2);
      wr(IDX_CMD, 32'h3);
      wait_st(k == 2 ? DHS_FAIL : DHS_RUN, 1);
      c1d = (k == 1);
      wr(IDX_CMD, k == 0 ? 32'h0 : 32'h3);
      wait_st(k == 0 ? DHS_IDLE : DHS_FAIL, 1);
      chk(refd, 1'b0, "unreferenced");
      c1d = 1'b0;
      pos_mode = 1'b1;
      wr(IDX_CMD, 32'h0);
      wait_st(DHS_IDLE, 0);
    end
    $display("abort test done");
    end_sim();
  end
endmodule : test_drive_homing_sequencer
bind dhs_sequencer dhs_asserts u_chk (.clk, .rst_n, .homing_command, .homing_method_code,
  .cyc_pos_cmd, .pos_mode, .marker_pin, .class_one_diagnostic_error, .standstill,
  .int_pos_ctrl, .move_en, .decel, .pos_cmd, .pos_referenced, .cmd_state);
`default_nettype wire
